// file: core/fircr_top.v
`timescale 1ns/1ps
`include "fircr_defines.vh"

// What this block does
// - Button press flags only in switch mode.
// - Overheat detector sets flag bit five.
// - Low input detector sets flag bit four.
// - Each channel power-good failure sets own flag.
// - Power-good flags suppressed during init, shutdown.
// - Masked events never drive interrupt pin.
// - Enable one passes event; zero blocks, default.
// - Button enable works only in switch mode.
// - Write a9 in switch mode forces shutdown.
// - Write 7f restores all register defaults.
// - Any unmasked set flag pulls interrupt low.
// - Flags stick; clear by write one, enables low.
module fircr_top (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       switch_mode,
  input  wire       manual_reset_button_n,
  input  wire       overheat_det,
  input  wire       low_input_det,
  input  wire [3:0] power_good_in,
  input  wire [3:0] channel_enable_pin,
  input  wire       initializing,
  input  wire       normal_shutdown,
  output wire       irq_out,
  output wire       irq_oe_n,
  output reg        shutdown_all,
  output reg        power_control_reset,
  output reg        restore_defaults
);

  // ========================================================================
  // Input synchronisation
  // All detector and pin inputs are asynchronous to ref_clk. The button is
  // inverted ahead of the synchroniser so that the cleared stages read as
  // released, which keeps a false press out of the cycles after reset.
  localparam SYNC_W = `FIRCR_SYNC_BITS;

  wire [SYNC_W-1:0] raw_in;
  wire [SYNC_W-1:0] syn_in;

  assign raw_in = {channel_enable_pin,
                   power_good_in,
                   normal_shutdown,
                   initializing,
                   low_input_det,
                   overheat_det,
                   ~manual_reset_button_n,
                   switch_mode};

  fircr_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .sync_out (syn_in)
  );

  wire       s_switch_mode;
  wire       s_button;
  wire       s_overheat;
  wire       s_low_input;
  wire       s_init;
  wire       s_shutdown;
  wire [3:0] s_pgood;
  wire [3:0] s_chan_en;

  assign s_switch_mode = syn_in[0];
  assign s_button      = syn_in[1];
  assign s_overheat    = syn_in[2];
  assign s_low_input   = syn_in[3];
  assign s_init        = syn_in[4];
  assign s_shutdown    = syn_in[5];
  assign s_pgood       = syn_in[9:6];
  assign s_chan_en     = syn_in[13:10];

  // ========================================================================
  // Event detection
  // Power-good failure is a falling edge so that a channel that has not yet
  // come up does not raise an event forever.
  reg  [3:0] pgood_prev;
  reg  [3:0] pgood_armed;
  wire [3:0] pgood_fall;
  wire [3:0] pgood_live;
  wire       pg_suppress;
  wire       button_event;
  wire [7:0] event_now;
  wire [7:0] cond_now;

  assign pg_suppress = s_init | s_shutdown;

  // ========================================================================
  // Per-channel power-good tracking
  // A channel is armed once its power-good has been high while enabled. An
  // armed channel whose power-good is still low keeps its fault live, so
  // the host cannot clear the flag until the rail has come back.
  genvar ch;
  generate
    for (ch = `FIRCR_PG_LSB; ch <= `FIRCR_PG_MSB; ch = ch + 1) begin : g_chan
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pgood_prev[ch]  <= 1'b0;
          pgood_armed[ch] <= 1'b0;
        end else begin
          pgood_prev[ch]  <= s_pgood[ch];
          pgood_armed[ch] <= (pgood_armed[ch] | s_pgood[ch]) & s_chan_en[ch];
        end
      end

      assign pgood_fall[ch] = pgood_prev[ch] & ~s_pgood[ch] &
                              ~pg_suppress;
      assign pgood_live[ch] = pgood_armed[ch] & ~s_pgood[ch] &
                              ~pg_suppress;
    end
  endgenerate

  // ========================================================================
  // Event and condition vectors
  // The button event is the level of a press, so it is also its own live
  // condition while the button stays down.
  assign button_event = s_button & s_switch_mode;

  assign event_now = {1'b0,
                      button_event,
                      s_overheat,
                      s_low_input,
                      pgood_fall};

  // Fault conditions still present block a write-one clear.
  assign cond_now = {1'b0,
                     button_event,
                     s_overheat,
                     s_low_input,
                     pgood_live};

  // ========================================================================
  // Register writes
  reg  [7:0] event_flags;
  reg  [7:0] event_enable;
  wire       wr_flags;
  wire       wr_enable;
  wire       wr_shutdown;
  wire       wr_restore;
  wire       do_restore;
  wire       all_en_low;
  wire [7:0] w1c_clear;
  wire [7:0] next_event_flags;

  assign wr_flags    = reg_wr & (reg_addr == `FIRCR_ADDR_FLAGS);
  assign wr_enable   = reg_wr & (reg_addr == `FIRCR_ADDR_ENABLE);
  assign wr_shutdown = reg_wr & (reg_addr == `FIRCR_ADDR_SHUTDOWN);
  assign wr_restore  = reg_wr & (reg_addr == `FIRCR_ADDR_RESTORE);
  assign do_restore  = wr_restore &
                       (reg_wdata == `FIRCR_RESTORE_MAGIC);
  assign all_en_low  = (s_chan_en == 4'h0);

  localparam [7:0] FLAGS_RST = `FIRCR_FLAGS_RESET;

  wire       wipe_flags;

  // All enable pins low or a restore wipes every flag that is not being
  // raised in the same cycle.
  assign wipe_flags = all_en_low | do_restore;

  // Write one clears, but not while the fault persists, and the set wins
  // over any clear in the same cycle, so an event is never lost to a clear.
  genvar b;
  generate
    for (b = 0; b < `FIRCR_REG_BITS; b = b + 1) begin : g_flag
      assign w1c_clear[b] = wr_flags & reg_wdata[b] &
                            ~cond_now[b];
      assign next_event_flags[b] = event_now[b] |
                                   (event_flags[b] & ~w1c_clear[b] &
                                    ~wipe_flags);

      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          event_flags[b] <= FLAGS_RST[b];
        end else begin
          event_flags[b] <= next_event_flags[b];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_enable <= `FIRCR_ENABLE_RESET;
    end else if (do_restore) begin
      event_enable <= `FIRCR_ENABLE_RESET;
    end else if (wr_enable) begin
      event_enable <= reg_wdata & `FIRCR_ENABLE_WMASK;
    end
  end

  // ========================================================================
  // Command pulses
  // Forced shutdown only acts in switch mode; other values are dropped.
  // Both pulses come from one decode so that they can never part company.
  wire shutdown_hit;

  assign shutdown_hit = wr_shutdown & s_switch_mode &
                        (reg_wdata == `FIRCR_SHUTDOWN_MAGIC);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_all        <= 1'b0;
      power_control_reset <= 1'b0;
      restore_defaults    <= 1'b0;
    end else begin
      shutdown_all        <= shutdown_hit;
      power_control_reset <= shutdown_hit;
      restore_defaults    <= do_restore;
    end
  end

  // ========================================================================
  // Interrupt pin
  wire [7:0] gate;
  wire       irq_active;

  // Button enable is honoured only in switch mode.
  assign gate = {1'b0,
                 event_enable[`FIRCR_BIT_BUTTON] & s_switch_mode,
                 event_enable[`FIRCR_BIT_OVERHEAT],
                 event_enable[`FIRCR_BIT_LOW_INPUT],
                 event_enable[`FIRCR_PG_MSB:`FIRCR_PG_LSB]};
  assign irq_active = |(event_flags & gate);

  // Open drain: enable is low while the pin is pulled low.
  assign irq_out  = 1'b0;
  assign irq_oe_n = ~irq_active;

  // ========================================================================
  // Register reads
  // Command registers are write-only and read back as zero, as do reserved
  // and unmapped addresses, so a host scan never sees a stale command byte.
  wire       rd_flags;
  wire       rd_enable;
  reg  [7:0] next_reg_rdata;

  assign rd_flags  = reg_rd & (reg_addr == `FIRCR_ADDR_FLAGS);
  assign rd_enable = reg_rd & (reg_addr == `FIRCR_ADDR_ENABLE);

  always @* begin
    next_reg_rdata = reg_rdata;
    if (rd_flags) begin
      next_reg_rdata = event_flags;
    end else if (rd_enable) begin
      next_reg_rdata = event_enable;
    end else if (reg_rd) begin
      next_reg_rdata = `FIRCR_ZERO_BYTE;
    end
  end

  // The read data holds until the next read strobe.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `FIRCR_ZERO_BYTE;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule // fircr_top

// file: core/fircr_defines.vh
`ifndef FIRCR_DEFINES_VH
`define FIRCR_DEFINES_VH
// ==========================================================================
// Register map
`define FIRCR_ADDR_FLAGS     8'h0e
`define FIRCR_ADDR_ENABLE    8'h0f
`define FIRCR_ADDR_SHUTDOWN  8'h10
`define FIRCR_ADDR_RESTORE   8'h11
// ==========================================================================
// Field positions
`define FIRCR_BIT_BUTTON     6
`define FIRCR_BIT_OVERHEAT   5
`define FIRCR_BIT_LOW_INPUT  4
`define FIRCR_PG_LSB         0
`define FIRCR_PG_MSB         3
`define FIRCR_REG_BITS       8
`define FIRCR_SYNC_BITS      14
// ==========================================================================
// Reset values and magic command values
`define FIRCR_FLAGS_RESET    8'h00
`define FIRCR_ENABLE_RESET   8'h00
`define FIRCR_ENABLE_WMASK   8'h7f
`define FIRCR_SHUTDOWN_MAGIC 8'ha9
`define FIRCR_RESTORE_MAGIC  8'h7f
`define FIRCR_ZERO_BYTE      8'h00
`endif

// file: core/fircr_sync.v
`timescale 1ns/1ps
// ==========================================================================
// Two-stage synchroniser, one per bit.
module fircr_sync #(
  parameter WIDTH = 8
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;
endmodule // fircr_sync

// file: tb/fircr_props.sv
`timescale 1ns/1ps
// ======
// Port checker.
module fircr_props (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       switch_mode,
  input wire logic       irq_oe_n,
  input wire logic       shutdown_all,
  input wire logic       power_control_reset,
  input wire logic       restore_defaults
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence shut_s;
    reg_wr && reg_addr == 8'h10 && reg_wdata == 8'ha9;
  endsequence
  sequence rest_s;
    reg_wr && reg_addr == 8'h11;
  endsequence
  // Mode passes two synchroniser stages, so it must hold three edges.
  shut_cmd_a: assert property (switch_mode[*3] ##0 shut_s |=> shutdown_all)
    else $error("shutdown pulse missing");
  shut_mode_a: assert property (!switch_mode[*3] ##0 shut_s |=> !shutdown_all)
    else $error("shutdown outside switch mode");
  shut_bad_a: assert property (reg_wr && reg_addr == 8'h10 && reg_wdata != 8'ha9
    |=> !shutdown_all) else $error("shutdown on wrong value");
  pctl_pair_a: assert property (shutdown_all == power_control_reset)
    else $error("control reset differs from shutdown");
  rest_cmd_a: assert property (rest_s ##0 reg_wdata == 8'h7f
    |=> restore_defaults && irq_oe_n) else $error("restore missing");
  rest_bad_a: assert property (rest_s ##0 reg_wdata != 8'h7f
    |=> !restore_defaults) else $error("restore on wrong value");
  unmap_rd_a: assert property (reg_rd && (reg_addr < 8'h0e || reg_addr > 8'h11)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  top_bit_a: assert property (reg_rd |=> !reg_rdata[7])
    else $error("bit 7 read as one");
  en_back_a: assert property ((reg_wr && reg_addr == 8'h0f) ##1 !reg_wr ##1
    (reg_rd && !reg_wr && reg_addr == 8'h0f)
    |=> reg_rdata == ($past(reg_wdata, 3) & 8'h7f)) else $error("enable readback");
endmodule // fircr_props

// file: tb/fircr_host.sv
`timescale 1ns/1ps
// ======
// Register host model.
module fircr_host (
  input  wire logic       ref_clk,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic [7:0]      reg_addr = 8'h00,
  output logic [7:0]      reg_wdata = 8'h00
);
  // Idle lines show the inverse of the last value, never a stale copy.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule // fircr_host

// file: tb/fircr_tb_top.sv
`timescale 1ns/1ps
// ======
// Bench top.
module fircr_tb_top;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr, reg_rd, irq_oe_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
  logic       sm = 1'b0, ini = 1'b0, nsd = 1'b0, rd_d = 1'b0;
  logic [3:0] cen = 4'hf;
  logic [7:0] ev = 8'h00;
  logic       sd, pcr, rdef, iro;
  integer     n_sd = 0, n_pcr = 0, n_rdef = 0;
  logic [7:0] exp_q[$];
  integer     seed = 99171, err_total = 0, samples_checked = 0, i;
  fircr_host host_u (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  fircr_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .switch_mode(sm), .manual_reset_button_n(!ev[6]),
    .overheat_det(ev[5]), .low_input_det(ev[4]), .power_good_in(~ev[3:0]),
    .channel_enable_pin(cen), .initializing(ini), .normal_shutdown(nsd),
    .irq_out(iro), .irq_oe_n(irq_oe_n), .shutdown_all(sd),
    .power_control_reset(pcr), .restore_defaults(rdef));
  // Command pulses are counted so that each write can be checked afterwards.
  always @(posedge ref_clk) begin
    if (sd) n_sd++;
    if (pcr) n_pcr++;
    if (rdef) n_rdef++;
  end
  initial forever #20 ref_clk = ~ref_clk;
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.rd(a);
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task irq(input logic e);
    chk("irq", {7'h00, e}, {7'h00, irq_oe_n});
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Read data is compared one edge after the read strobe was taken.
  always @(posedge ref_clk) begin
    if (rd_d) chk("rdata", exp_q.pop_front(), reg_rdata);
    rd_d <= reg_rd;
  end
  initial begin
    #200000;
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    cyc(3);
    rdx(8'h0e, 8'h00);
    rdx(8'h0f, 8'h00);
    rdx(8'h21, 8'h00);
    r = 8'($random(seed));
    host_u.wr(8'h0f, r);
    rdx(8'h0f, r & 8'h7f);
    sm = 1'b1;
    host_u.wr(8'h0f, 8'h7f);
    for (i = 0; i < 7; i++) begin
      ev = 8'h01 << i;
      cyc(5);
      irq(1'b0);
      host_u.wr(8'h0e, ev);
      rdx(8'h0e, ev);
      ev = 8'h00;
      cyc(5);
      host_u.wr(8'h0e, 8'h01 << i);
      rdx(8'h0e, 8'h00);
      irq(1'b1);
    end
    host_u.wr(8'h0f, 8'h00);
    ev = 8'h20;
    cyc(5);
    irq(1'b1);
    host_u.wr(8'h0f, 8'h20);
    irq(1'b0);
    cen = 4'h0;
    ev = 8'h00;
    cyc(5);
    rdx(8'h0e, 8'h00);
    cen = 4'hf;
    for (i = 0; i < 2; i++) begin
      {ini, nsd} = 2'b01 << i;
      ev = 8'h0f;
      cyc(5);
      rdx(8'h0e, 8'h00);
      ev = 8'h00;
      cyc(5);
    end
    {ini, nsd} = 2'b00;
    sm = 1'b0;
    ev = 8'h40;
    cyc(5);
    rdx(8'h0e, 8'h00);
    ev = 8'h00;
    host_u.wr(8'h10, 8'ha9);
    cyc(2);
    chk("shutdown", 8'h00, 8'(n_sd));
    sm = 1'b1;
    cyc(3);
    host_u.wr(8'h10, 8'ha9);
    host_u.wr(8'h10, 8'h5a);
    cyc(2);
    chk("shutdown", 8'h01, 8'(n_sd));
    chk("pctl_reset", 8'h01, 8'(n_pcr));
    ev = 8'h20;
    cyc(5);
    ev = 8'h00;
    host_u.wr(8'h11, 8'h7e);
    rdx(8'h0f, 8'h20);
    chk("restore", 8'h00, 8'(n_rdef));
    host_u.wr(8'h11, 8'h7f);
    rdx(8'h0e, 8'h00);
    rdx(8'h0f, 8'h00);
    cyc(2);
    chk("restore", 8'h01, 8'(n_rdef));
    chk("irq_out", 8'h00, {7'h00, iro});
    wrap_up;
  end
endmodule // fircr_tb_top

bind fircr_top fircr_props chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .switch_mode(switch_mode),
  .irq_oe_n(irq_oe_n), .shutdown_all(shutdown_all),
  .power_control_reset(power_control_reset),
  .restore_defaults(restore_defaults));
